// >>> rtl/adc_ref_tenbit_sequencer.sv
// Successive-approximation converter control with programmable reference taps
// and a two-pass ten-bit sequencer, reached over AXI4-Lite.
// Assumes an external ladder, sample switch and comparator; the comparator
// output is asynchronous and is synchronised here.
`timescale 1ns/1ns
module adc_ref_tenbit_sequencer (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire adc_seq_pkg::addr_t    awaddr,
  // AXI4-Lite write data
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire adc_seq_pkg::word_t    wdata,
  input  wire adc_seq_pkg::strb_t    wstrb,
  // AXI4-Lite write response
  output logic                       bvalid,
  input  wire logic                  bready,
  output adc_seq_pkg::resp_t         bresp,
  // AXI4-Lite read address
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire adc_seq_pkg::addr_t    araddr,
  // AXI4-Lite read data
  output logic                       rvalid,
  input  wire logic                  rready,
  output adc_seq_pkg::word_t         rdata,
  output adc_seq_pkg::resp_t         rresp,
  // Analog front end
  output adc_seq_pkg::chan_t         analog_channel,
  output logic                       sample_hold,
  output adc_seq_pkg::byte_t         dac_code,
  input  wire logic                  cmp_above,
  output adc_seq_pkg::nib_t          internal_upper_ref,
  output adc_seq_pkg::nib_t          internal_lower_ref,
  // Processor side status
  output logic                       conversion_busy_flag,
  output logic                       eoc_irq
);
  import adc_seq_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_SAMPLE, C_SAR, C_HOLD} conv_state_t;
  typedef enum logic [2:0] {S_IDLE, S_COARSE_SET, S_COARSE_WAIT, S_LOOKUP,
                            S_NARROW_SET, S_NARROW_WAIT, S_MERGE} seq_state_t;

  conv_state_t cst_r, cst_nxt;
  seq_state_t  sst_r, sst_nxt;
  cnt_t        cyc_r;
  cnt_t        step_r;
  logic [2:0]  bit_r;
  byte_t       sar_r;
  byte_t       ref_r;
  byte_t       result_r;
  byte_t       sel_r;
  tenbit_t     ten_r;
  chan_t       chan_r;
  chan_t       conv_chan_r;
  logic        cont_r;
  logic        tenbit_mode_r;
  logic        irq_en_r;
  logic        eoc_flag_r;
  logic        ten_flag_r;
  logic        cont_pend_r;
  logic        cmp_meta_r;
  logic        cmp_sync_r;
  byte_t       lut_data;
  // Bus slave state
  logic        aw_hold_r;
  addr_t       awaddr_r;
  logic        w_hold_r;
  word_t       wdata_r;
  strb_t       wstrb_r;
  logic        bvalid_r;
  resp_t       bresp_r;
  logic        rvalid_r;
  word_t       rdata_r;
  resp_t       rresp_r;

  function automatic logic addr_ok(input addr_t a);
    addr_ok = (a == OFS_REF) || (a == OFS_CTRL) || (a == OFS_STATUS) ||
              (a == OFS_RESULT) || (a == OFS_TENBIT);
  endfunction

  // Keep or drop the trial bit, then try the next lower one
  function automatic byte_t sar_step(input byte_t t, input logic [2:0] b, input logic above);
    byte_t v;
    v = t;
    if (!above) v[b] = 1'b0;
    if (b != 3'h0) v[b - 3'h1] = 1'b1;
    sar_step = v;
  endfunction

  function automatic tenbit_t merge(input byte_t sel, input byte_t res);
    logic [8:0] s;
    logic [1:0] m;
    s = {1'b0, res} + (sel[SEL_PARITY] ? {1'b0, EVEN_OFFSET} : 9'h000);
    m = sel[SEL_MSB_LSB +: 2] + {1'b0, s[8]};
    merge = {m, s[7:0]};
  endfunction

  // Register bus decode
  wire do_write  = aw_hold_r & w_hold_r & ~bvalid_r;
  wire wr_lane0  = do_write & wstrb_r[0];
  wire wr_ref    = wr_lane0 & (awaddr_r == OFS_REF);
  wire wr_ctrl   = wr_lane0 & (awaddr_r == OFS_CTRL);
  wire wr_stat   = wr_lane0 & (awaddr_r == OFS_STATUS);
  wire rd_take   = arvalid & ~rvalid_r;

  wire conv_idle   = (cst_r == C_IDLE);
  wire seq_idle    = (sst_r == S_IDLE);
  wire sw_start    = wr_ctrl & wdata_r[CTRL_START] & conv_idle & seq_idle & ~cont_pend_r;
  wire sw_ten_start = sw_start & wdata_r[CTRL_TENBIT];
  wire seq_ref_wr  = (sst_r == S_COARSE_SET) | (sst_r == S_NARROW_SET);
  wire conv_start  = (sw_start & ~wdata_r[CTRL_TENBIT]) | seq_ref_wr | cont_pend_r;
  wire sample_last = (cst_r == C_SAMPLE) & (cyc_r == SAMPLE_LAST);
  wire step_last   = (cst_r == C_SAR) & (step_r == STEP_LAST);
  wire sar_last    = step_last & (bit_r == 3'h0);
  wire conv_done   = (cst_r == C_HOLD) & (cyc_r == CONV_LAST);
  wire chan_t chan_src = wr_ctrl ? wdata_r[CTRL_CHAN +: 3] : chan_r;

  wire word_t ctrl_word = {25'h0000000, irq_en_r, tenbit_mode_r, chan_r, cont_r, 1'b0};
  wire word_t stat_word = {28'h0000000, ~seq_idle, ten_flag_r, eoc_flag_r, ~conv_idle};
  wire word_t rd_word =
    (araddr == OFS_REF)    ? {24'h000000, ref_r} :
    (araddr == OFS_CTRL)   ? ctrl_word :
    (araddr == OFS_STATUS) ? stat_word :
    (araddr == OFS_RESULT) ? {24'h000000, result_r} :
    (araddr == OFS_TENBIT) ? {22'h000000, ten_r} : 32'h00000000;

  assign awready = ~aw_hold_r;
  assign wready  = ~w_hold_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = ~rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  // Ladder taps follow the register directly, so a write retargets at once while the sequencer is idle
  assign internal_upper_ref   = ref_r[REF_UPPER_LSB +: 4];
  assign internal_lower_ref   = ref_r[REF_LOWER_LSB +: 4];
  assign analog_channel       = conv_chan_r;
  assign sample_hold          = (cst_r == C_SAMPLE);
  assign dac_code             = sar_r;
  assign conversion_busy_flag = ~conv_idle;
  assign eoc_irq              = eoc_flag_r & irq_en_r;

  ref_lut_rom u_lut (
    .aclk    (aclk),
    .aresetn (aresetn),
    .addr    (result_r[7:4]),
    .data    (lut_data)
  );

  always_comb begin
    cst_nxt = cst_r;
    case (cst_r)
      C_IDLE:   if (conv_start) cst_nxt = C_SAMPLE;
      C_SAMPLE: if (sample_last) cst_nxt = C_SAR;
      C_SAR:    if (sar_last) cst_nxt = C_HOLD;
      C_HOLD:   if (conv_done) cst_nxt = C_IDLE;
      default:  cst_nxt = C_IDLE;
    endcase
  end

  always_comb begin
    sst_nxt = sst_r;
    case (sst_r)
      S_IDLE:        if (sw_ten_start) sst_nxt = S_COARSE_SET;
      S_COARSE_SET:  sst_nxt = S_COARSE_WAIT;
      S_COARSE_WAIT: if (conv_done) sst_nxt = S_LOOKUP;
      S_LOOKUP:      sst_nxt = S_NARROW_SET;
      S_NARROW_SET:  sst_nxt = S_NARROW_WAIT;
      S_NARROW_WAIT: if (conv_done) sst_nxt = S_MERGE;
      S_MERGE:       sst_nxt = cont_r ? S_COARSE_SET : S_IDLE;
      default:       sst_nxt = S_IDLE;
    endcase
  end

  // Conversion datapath
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cst_r <= C_IDLE;
      cyc_r <= 12'h000;
      step_r <= 12'h000;
      bit_r <= SAR_TOP;
      sar_r <= 8'h00;
      result_r <= 8'h00;
      conv_chan_r <= 3'h0;
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
    end else begin
      cst_r <= cst_nxt;
      cmp_meta_r <= cmp_above;
      cmp_sync_r <= cmp_meta_r;
      cyc_r <= conv_start ? 12'h000 : cyc_r + 12'h001;
      step_r <= (sample_last | step_last) ? 12'h000 : step_r + 12'h001;
      if (conv_start) conv_chan_r <= chan_src;
      if (sample_last) begin
        sar_r <= SAR_FIRST;
        bit_r <= SAR_TOP;
      end else if (step_last) begin
        sar_r <= sar_step(sar_r, bit_r, cmp_sync_r);
        bit_r <= bit_r - 3'h1;
      end
      if (conv_done) result_r <= sar_r;
    end
  end

  // Registers, flags and sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sst_r <= S_IDLE;
      ref_r <= REF_RESET;
      sel_r <= REF_RESET;
      ten_r <= 10'h000;
      chan_r <= 3'h0;
      cont_r <= 1'b0;
      tenbit_mode_r <= 1'b0;
      irq_en_r <= 1'b0;
      eoc_flag_r <= 1'b0;
      ten_flag_r <= 1'b0;
      cont_pend_r <= 1'b0;
    end else begin
      sst_r <= sst_nxt;
      if (sst_r == S_COARSE_SET) ref_r <= FULL_RANGE_REF;
      else if (sst_r == S_NARROW_SET) ref_r <= lut_data;
      else if (wr_ref & seq_idle) ref_r <= wdata_r[7:0];
      if (sst_r == S_NARROW_SET) sel_r <= lut_data;
      if (sst_r == S_MERGE) ten_r <= merge(sel_r, result_r);
      if (wr_ctrl) begin
        cont_r <= wdata_r[CTRL_CONT];
        chan_r <= wdata_r[CTRL_CHAN +: 3];
        tenbit_mode_r <= wdata_r[CTRL_TENBIT];
        irq_en_r <= wdata_r[CTRL_IRQEN];
      end
      // Hardware set beats a same-cycle software clear
      if (conv_done) eoc_flag_r <= 1'b1;
      else if (wr_stat & wdata_r[STAT_EOC]) eoc_flag_r <= 1'b0;
      if (sst_r == S_MERGE) ten_flag_r <= 1'b1;
      else if (wr_stat & wdata_r[STAT_TEN]) ten_flag_r <= 1'b0;
      cont_pend_r <= conv_done & cont_r & seq_idle;
    end
  end

  // AXI4-Lite slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      w_hold_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else begin
      if (awvalid & ~aw_hold_r) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= awaddr;
      end else if (do_write) aw_hold_r <= 1'b0;
      if (wvalid & ~w_hold_r) begin
        w_hold_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end else if (do_write) w_hold_r <= 1'b0;
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r <= addr_ok(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) bvalid_r <= 1'b0;
      if (rd_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) rvalid_r <= 1'b0;
    end
  end

  // Checks
  cnt_t busy_len_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) busy_len_r <= 12'h000;
    else busy_len_r <= conversion_busy_flag ? busy_len_r + 12'h001 : 12'h000;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_start;
    conv_start && conv_idle;
  endsequence
  sequence s_ten_begin;
    sw_ten_start ##1 (sst_r == S_COARSE_SET);
  endsequence

  property p_busy_rise;
    s_start |=> conversion_busy_flag && sample_hold;
  endproperty
  property p_sample_len;
    $fell(sample_hold) && conversion_busy_flag |-> $past(cyc_r) == SAMPLE_LAST;
  endproperty
  property p_conv_len;
    $fell(conversion_busy_flag) |-> busy_len_r == CONV_CYCLES;
  endproperty
  property p_chan_stable;
    conversion_busy_flag && $past(conversion_busy_flag) |-> $stable(analog_channel);
  endproperty
  property p_cont;
    conv_done && cont_r && seq_idle |-> ##2 sample_hold;
  endproperty
  property p_irq;
    conv_done && irq_en_r |=> eoc_irq;
  endproperty
  property p_ref_write;
    wr_ref && seq_idle && !seq_ref_wr |=> internal_upper_ref == $past(wdata_r[7:4])
      && internal_lower_ref == $past(wdata_r[3:0]);
  endproperty
  property p_seq_wait;
    seq_ref_wr |-> !conversion_busy_flag;
  endproperty
  property p_coarse;
    s_ten_begin |=> ref_r == FULL_RANGE_REF && conversion_busy_flag;
  endproperty
  property p_lut;
    sst_r == S_NARROW_SET |=> ref_r == $past(lut_data) && sel_r == ref_r;
  endproperty
  property p_odd;
    sst_r == S_MERGE && !sel_r[SEL_PARITY] |=> ten_r[7:0] == $past(result_r);
  endproperty
  property p_even;
    sst_r == S_MERGE && sel_r[SEL_PARITY] |=> ten_r[7:0] == $past(result_r) + EVEN_OFFSET;
  endproperty
  property p_msb;
    sst_r == S_MERGE && !sel_r[SEL_PARITY] |=> ten_r[9:8] == $past(sel_r[3:2]);
  endproperty

  a_busy_rise:   assert property (p_busy_rise)   else $error("busy not raised on start");
  a_sample_len:  assert property (p_sample_len)  else $error("sample window length wrong");
  a_conv_len:    assert property (p_conv_len)    else $error("conversion length wrong");
  a_chan_stable: assert property (p_chan_stable) else $error("channel moved mid conversion");
  a_cont:        assert property (p_cont)        else $error("continuous restart missing");
  a_irq:         assert property (p_irq)         else $error("interrupt not raised");
  a_ref_write:   assert property (p_ref_write)   else $error("reference taps not updated");
  a_seq_wait:    assert property (p_seq_wait)    else $error("sequencer wrote while busy");
  a_coarse:      assert property (p_coarse)      else $error("coarse pass not full range");
  a_lut:         assert property (p_lut)         else $error("narrow reference not from table");
  a_odd:         assert property (p_odd)         else $error("odd sub-range low bits wrong");
  a_even:        assert property (p_even)        else $error("even sub-range offset wrong");
  a_msb:         assert property (p_msb)         else $error("top result bits wrong");
endmodule

// >>> rtl/adc_seq_pkg.sv
// Shared constants and types for the reference-programmable converter control block.
// Assumes a single 250 MHz clock; analog front end and ladder live outside.
package adc_seq_pkg;
  typedef logic [7:0]  addr_t;
  typedef logic [31:0] word_t;
  typedef logic [3:0]  strb_t;
  typedef logic [1:0]  resp_t;
  typedef logic [7:0]  byte_t;
  typedef logic [3:0]  nib_t;
  typedef logic [2:0]  chan_t;
  typedef logic [9:0]  tenbit_t;
  typedef logic [11:0] cnt_t;

  // Timing: a machine cycle is 12 oscillator periods at 12 MHz
  localparam int CLK_PERIOD_NS    = 4;
  localparam int OSC_MHZ          = 12;
  localparam int OSC_PER_MC       = 12;
  localparam int MACHINE_CYCLE_NS = (OSC_PER_MC * 1000) / OSC_MHZ;
  localparam int SAMPLE_MC        = 5;
  localparam int CONV_TIME_US     = 10;
  localparam int SAR_BITS         = 8;
  localparam int MC_CYCLES        = (MACHINE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CYCLES    = SAMPLE_MC * MC_CYCLES;
  localparam int CONV_CYCLES      = (CONV_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int STEP_CYCLES      = (CONV_CYCLES - SAMPLE_CYCLES) / (SAR_BITS + 1);
  localparam cnt_t SAMPLE_LAST    = cnt_t'(SAMPLE_CYCLES - 1);
  localparam cnt_t CONV_LAST      = cnt_t'(CONV_CYCLES - 1);
  localparam cnt_t STEP_LAST      = cnt_t'(STEP_CYCLES - 1);

  // Register offsets (byte addresses)
  localparam addr_t OFS_REF    = 8'h00;
  localparam addr_t OFS_CTRL   = 8'h04;
  localparam addr_t OFS_STATUS = 8'h08;
  localparam addr_t OFS_RESULT = 8'h0C;
  localparam addr_t OFS_TENBIT = 8'h10;

  // Control fields
  localparam int CTRL_START  = 0;
  localparam int CTRL_CONT   = 1;
  localparam int CTRL_CHAN   = 2;
  localparam int CTRL_TENBIT = 5;
  localparam int CTRL_IRQEN  = 6;
  // Status fields
  localparam int STAT_BUSY   = 0;
  localparam int STAT_EOC    = 1;
  localparam int STAT_TEN    = 2;
  localparam int STAT_SEQ    = 3;

  // Reference-select layout and values
  localparam int    REF_LOWER_LSB  = 0;
  localparam int    REF_UPPER_LSB  = 4;
  localparam int    SEL_PARITY     = 1;
  localparam int    SEL_MSB_LSB    = 2;
  localparam byte_t REF_RESET      = 8'h00;
  localparam byte_t FULL_RANGE_REF = 8'h00;
  localparam byte_t EVEN_OFFSET    = 8'h80;
  localparam byte_t SAR_FIRST      = 8'h80;
  localparam logic [2:0] SAR_TOP   = 3'h7;

  localparam resp_t RESP_OKAY   = 2'h0;
  localparam resp_t RESP_SLVERR = 2'h2;
endpackage

// >>> rtl/ref_lut_rom.sv
// Sub-range lookup: coarse upper nibble in, narrow reference-select value out.
// Read data is registered; one cycle from address to data.
`timescale 1ns/1ns
module ref_lut_rom (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Lookup port
  input  wire adc_seq_pkg::nib_t  addr,
  output adc_seq_pkg::byte_t      data
);
  import adc_seq_pkg::*;

  // Seven 1.28 V windows in 0.32 V ladder steps; even windows sit 0.64 V up
  function automatic byte_t lut_entry(input nib_t a);
    case (a)
      4'h0, 4'h1: lut_entry = 8'h40;
      4'h2, 4'h3: lut_entry = 8'h62;
      4'h4, 4'h5: lut_entry = 8'h84;
      4'h6, 4'h7: lut_entry = 8'hA6;
      4'h8, 4'h9: lut_entry = 8'hC8;
      4'hA, 4'hB: lut_entry = 8'hEA;
      default:    lut_entry = 8'h0C;
    endcase
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data <= REF_RESET;
    end else begin
      data <= lut_entry(addr);
    end
  end
endmodule

// >>> tb/analog_src_model.sv
// Far-side model: eight analog input levels, sample switch, ladder and comparator.
// Levels are in 5 mV units (0 to 3FF); the bench sets them before any conversion.
`timescale 1ns/1ns
module analog_src_model (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Converter side
  input  wire adc_seq_pkg::chan_t      chan,
  input  wire logic                    sample_hold,
  input  wire adc_seq_pkg::byte_t      dac_code,
  input  wire adc_seq_pkg::nib_t       upper,
  input  wire adc_seq_pkg::nib_t       lower,
  output logic                         cmp_above,
  // Input levels
  input  wire adc_seq_pkg::tenbit_t [7:0] level
);
  import adc_seq_pkg::*;
  tenbit_t     held_r;
  logic [18:0] vlo;
  logic [18:0] vhi;
  logic [18:0] trial;
  // Taps in sixteenths; upper code 0 stands for the full external reference
  assign vlo = {9'h000, lower, 6'h00};
  assign vhi = (upper == 4'h0) ? 19'h00400 : {9'h000, upper, 6'h00};
  assign trial = vlo + ((19'(dac_code) * (vhi - vlo)) >> 8);
  assign cmp_above = {9'h000, held_r} >= trial;
  // Held level stays frozen outside the sample phase
  always_ff @(posedge aclk) begin
    if (!aresetn) held_r <= 10'h000;
    else if (sample_hold) held_r <= level[chan];
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench: AXI4-Lite master tasks, one task per scenario.
// Assumes the converter block and the analog model; 250 MHz clock.
`timescale 1ns/1ns
module tb_top;
  import adc_seq_pkg::*;
  logic    aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic    awready, wready, bvalid, arready, rvalid, cmp_above, sample_hold, busy, irq;
  addr_t   awaddr, araddr;
  word_t   wdata, rdata, rd_d;
  strb_t   wstrb;
  resp_t   bresp, rresp, r;
  chan_t   ch;
  byte_t   dac;
  nib_t    up, lo;
  tenbit_t [7:0] level;
  int      error_cnt, checks_done;
  int      busy_run, samp_run, last_busy, last_samp;

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  adc_ref_tenbit_sequencer uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .analog_channel(ch), .sample_hold(sample_hold), .dac_code(dac),
    .cmp_above(cmp_above), .internal_upper_ref(up), .internal_lower_ref(lo),
    .conversion_busy_flag(busy), .eoc_irq(irq));

  analog_src_model model (.aclk(aclk), .aresetn(aresetn), .chan(ch),
    .sample_hold(sample_hold), .dac_code(dac), .upper(up), .lower(lo),
    .cmp_above(cmp_above), .level(level));

  // Lengths of each busy run, latched at the edge that first sees busy low; a task
  // returning after the start edge would otherwise miss the first busy cycle
  always @(posedge aclk) begin
    if (busy === 1'b1) begin
      busy_run <= busy_run + 1;
      samp_run <= samp_run + int'(sample_hold);
    end else if (busy_run != 0) begin
      last_busy <= busy_run;
      last_samp <= samp_run;
      busy_run  <= 0;
      samp_run  <= 0;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Address and data offered together, each released once taken
  task wr(input addr_t a, input word_t d);
    logic aw_hs, w_hs, b_hs;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      #1;
      aw_hs = awvalid && awready;
      w_hs  = wvalid && wready;
      b_hs  = bvalid && bready;
      r     = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task rd(input addr_t a);
    logic ar_hs, r_hs;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      #1;
      ar_hs = arvalid && arready;
      r_hs  = rvalid && rready;
      rd_d  = rdata;
      r     = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // Follows one conversion: checks busy and sample cycle counts, refs checked at start and end
  task wait_conv(input nib_t eu, input nib_t el, input chan_t ec);
    int n, nb;
    n = 0;
    nb = 0;
    #1;
    while (busy !== 1'b1 && n < 20) begin
      @(posedge aclk);
      #1;
      n++;
    end
    check({ch, up, lo}, {ec, eu, el});
    while (busy === 1'b1 && nb < 3000) begin
      nb++;
      @(posedge aclk);
      #1;
    end
    @(posedge aclk);
    #1;
    check(last_busy, CONV_CYCLES);
    check(last_samp, SAMPLE_CYCLES);
    check({ch, up, lo}, {ec, eu, el});
  endtask

  function automatic byte_t exp8(input tenbit_t v, input byte_t rs);
    int lv, hv, d;
    lv = rs[3:0] * 64;
    hv = (rs[7:4] == 4'h0) ? 1024 : rs[7:4] * 64;
    d = (int'(v) - lv) * 256 / (hv - lv);
    if (d < 0) d = 0;
    if (d > 255) d = 255;
    return byte_t'(d);
  endfunction

  function automatic byte_t lut(input nib_t n);
    case (n[3:1])
      3'h0: return 8'h40;
      3'h1: return 8'h62;
      3'h2: return 8'h84;
      3'h3: return 8'hA6;
      3'h4: return 8'hC8;
      3'h5: return 8'hEA;
      default: return 8'h0C;
    endcase
  endfunction

  task t_regs;
    rd(OFS_REF);
    check(rd_d, 32'h0);
    rd(8'h14);
    check(rd_d, 32'h0);
    check(32'(r), 32'(RESP_SLVERR));
    wr(OFS_REF, 32'hC4);
    check(r, RESP_OKAY);
    check({up, lo}, 8'hC4);
    rd(OFS_REF);
    check(rd_d, 32'hC4);
  endtask

  task t_single;
    for (int c = 0; c < 8; c++) begin
      wr(OFS_REF, 32'h0);
      wr(OFS_CTRL, {25'h0, c[0], 1'b0, c[2:0], 2'h1});
      wait_conv(4'h0, 4'h0, c[2:0]);
      rd(OFS_RESULT);
      check(rd_d, {24'h0, exp8(level[c], 8'h00)});
      rd(OFS_STATUS);
      check(rd_d[1:0], 2'h2);
      check(irq, c[0]);
      wr(OFS_STATUS, 32'h2);
      check(irq, 1'b0);
    end
  endtask

  task t_narrow;
    wr(OFS_REF, 32'h84);
    wr(OFS_CTRL, 32'h0D);
    wait_conv(4'h8, 4'h4, 3'h3);
    rd(OFS_RESULT);
    check(rd_d, {24'h0, exp8(level[3], 8'h84)});
    wr(OFS_STATUS, 32'h2);
  endtask

  task t_tenbit;
    byte_t   co, sel, nr;
    logic [8:0] s9;
    tenbit_t ex;
    int      n;
    for (int c = 1; c < 8; c++) begin
      co = exp8(level[c], 8'h00);
      sel = lut(co[7:4]);
      nr = exp8(level[c], sel);
      s9 = {1'b0, nr} + (sel[1] ? 9'h080 : 9'h000);
      ex = {sel[3:2] + {1'b0, s9[8]}, s9[7:0]};
      wr(OFS_CTRL, {27'h1, c[2:0], 2'h1});
      wait_conv(4'h0, 4'h0, c[2:0]);
      wait_conv(sel[7:4], sel[3:0], c[2:0]);
      n = 0;
      rd(OFS_STATUS);
      while (rd_d[2] !== 1'b1 && n < 10) begin
        rd(OFS_STATUS);
        n++;
      end
      rd(OFS_RESULT);
      check(rd_d, {24'h0, nr});
      rd(OFS_TENBIT);
      check(rd_d, {22'h0, ex});
      wr(OFS_STATUS, 32'h6);
      c = c + 1;
    end
  endtask

  task t_cont;
    int n;
    wr(OFS_REF, 32'h0);
    wr(OFS_CTRL, 32'h0B);
    wait_conv(4'h0, 4'h0, 3'h2);
    @(posedge aclk);
    #1;
    check(busy, 1'b1);
    rd(OFS_STATUS);
    check(rd_d[0], 1'b1);
    wr(OFS_CTRL, 32'h08);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge aclk);
      #1;
      n++;
    end
    repeat (20) @(posedge aclk);
    #1;
    check(busy, 1'b0);
    rd(OFS_RESULT);
    check(rd_d, {24'h0, exp8(level[2], 8'h00)});
  endtask

  initial begin
    #(4 * 90000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    error_cnt = 0;
    checks_done = 0;
    busy_run = 0;
    samp_run = 0;
    last_busy = 0;
    last_samp = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    level = {10'h3FF, 10'h3E8, 10'h2BC, 10'h190, 10'h12C, 10'h0C8, 10'h064, 10'h000};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_single();
    t_narrow();
    t_tenbit();
    t_cont();
    print_verdict();
  end
endmodule
